// ==== design/link_mode_cfg.sv ====
`timescale 1ns/1ps
`default_nettype none
module link_mode_cfg
  import link_cfg_pkg::*;
#(
  parameter int NUM_LANES = 16
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [DATA_W-1:0]      reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [DATA_W-1:0]      reg_rdata,
  input  wire logic                   cal_done,
  output logic                        link_block_enable,
  output logic                        interleave_flag,
  output logic      [1:0]             sample_rate_mult,
  output logic                        ch_a_source,
  output logic                        ch_b_source,
  output logic                        ch_b_phase_invert,
  output logic                        datapath_single_channel,
  output logic      [5:0]             lane_rate_mult_x8,
  output logic                        serdes_pll_bypass,
  output logic                        encoding_64b66b,
  output logic                        ilas_enable,
  output logic      [8:0]             frames_per_multiframe,
  output logic      [7:0]             ext_multiblocks,
  output logic      [DID_W-1:0]       ilas_did,
  output logic                        ilas_scr,
  output logic      [3:0]             ilas_lanes_m1,
  output logic      [3:0]             ilas_octets_m1,
  output logic      [7:0]             ilas_frames_m1,
  output logic      [3:0]             ilas_conv_m1,
  output logic      [4:0]             ilas_res_m1,
  output logic      [4:0]             ilas_bits_m1,
  output logic      [3:0]             ilas_samples_m1,
  output logic      [1:0]             ilas_cs,
  output logic                        ilas_hd,
  output logic      [2:0]             ilas_jesdv,
  output logic      [2:0]             ilas_subclassv,
  output logic      [NUM_LANES-1:0]   lane_active,
  output logic      [NUM_LANES*5-1:0] ilas_lane_id,
  output logic      [NUM_LANES*8-1:0] ilas_checksum
);

  if (NUM_LANES < 16 || NUM_LANES > 32)
  begin : g_lane_check
    $error("link_mode_cfg: NUM_LANES must lie between 16 and 32");
  end

  logic [FORMAT_W-1:0] format_sel;
  logic [FRAMES_W-1:0] frames_field;
  logic [DID_W-1:0]    device_id;
  logic                scr_en;
  logic                enc_64;
  logic [1:0]          input_sel_req;
  logic [1:0]          active_sel;
  logic                cal_pending;
  logic [FORMAT_W-1:0] cfg_format;
  logic [FRAMES_W-1:0] cfg_frames;
  logic [DID_W-1:0]    cfg_did;
  logic                cfg_scr;
  logic                cfg_enc;
  logic                rom_valid;
  logic                rom_intlv;
  logic [4:0]          rom_n;
  logic [1:0]          rom_cs;
  logic [4:0]          rom_np;
  logic [3:0]          rom_l;
  logic [3:0]          rom_m;
  logic [3:0]          rom_f;
  logic [3:0]          rom_s;
  logic                rom_hd;
  logic [5:0]          rom_r_x8;
  logic [5:0]          rom_kmin;
  logic [4:0]          rom_kstep;
  logic [8:0]          k_value;
  logic                k_valid;
  logic [NUM_LANES*5-1:0] next_lane_id;
  logic [NUM_LANES-1:0]   next_lane_active;
  logic [DATA_W-1:0]      status_word;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // zero-valued fields (adjust count/dir, bank, cf, cs, hd, reserved) add nothing
  function automatic logic [7:0] ilas_sum(input logic [4:0] lid);
    ilas_sum = cfg_did + 8'(lid) + 8'(cfg_scr) + 8'(rom_l) + 8'(rom_f) + cfg_frames
             + 8'(rom_m) + 8'(rom_n) + 8'(rom_np) + 8'(rom_s) + 8'(ILAS_JESDV)
             + 8'(ILAS_SUBCLASSV) - 8'h06;
  endfunction

  // software registers; writes land even while the link runs, but the transport fields are not used then
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      format_sel        <= RST_FORMAT;
      frames_field      <= RST_FRAMES;
      device_id         <= RST_DID;
      scr_en            <= RST_SCR;
      enc_64            <= RST_ENC;
      link_block_enable <= RST_EN;
      input_sel_req     <= SEL_IN_A;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, OFS_FORMAT))
        format_sel <= reg_wdata[FORMAT_W-1:0];
      if (hit(reg_addr, OFS_FRAMES))
        frames_field <= reg_wdata[FRAMES_W-1:0];
      if (hit(reg_addr, OFS_DEVICE_ID))
        device_id <= reg_wdata[DID_W-1:0];
      if (hit(reg_addr, OFS_LINK_CTRL))
      begin
        scr_en <= reg_wdata[CTRL_SCR_BIT];
        enc_64 <= reg_wdata[CTRL_ENC_BIT];
      end
      if (hit(reg_addr, OFS_LINK_EN))
        link_block_enable <= reg_wdata[LINK_EN_BIT];
      if (hit(reg_addr, OFS_INPUT_SEL))
        input_sel_req <= reg_wdata[1:0];
    end
  end

  // the transport snapshot follows software only while the link is held off
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cfg_format <= RST_FORMAT;
      cfg_frames <= RST_FRAMES;
      cfg_did    <= RST_DID;
      cfg_scr    <= RST_SCR;
      cfg_enc    <= RST_ENC;
    end
    else if (!link_block_enable)
    begin
      cfg_format <= format_sel;
      cfg_frames <= frames_field;
      cfg_did    <= device_id;
      cfg_scr    <= scr_en;
      cfg_enc    <= enc_64;
    end
  end

  // routing changes only on calibration; a write in the same cycle stays pending
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      active_sel  <= SEL_IN_A;
      cal_pending <= 1'b0;
    end
    else
    begin
      if (cal_done)
        active_sel <= input_sel_req;
      if (cal_done)
        cal_pending <= 1'b0;
      if (reg_wr && hit(reg_addr, OFS_INPUT_SEL))
        cal_pending <= 1'b1;
    end
  end

  link_mode_rom u_rom (
    .clk_sys           (clk_sys),
    .rst_n             (rst_n),
    .format_sel        (cfg_format),
    .mode_valid        (rom_valid),
    .mode_interleave   (rom_intlv),
    .sample_bits       (rom_n),
    .ctrl_bits         (rom_cs),
    .packed_bits       (rom_np),
    .lanes_per_link    (rom_l),
    .converters        (rom_m),
    .octets_per_frame  (rom_f),
    .samples_per_frame (rom_s),
    .mode_high_density (rom_hd),
    .rate_x8           (rom_r_x8),
    .k_min             (rom_kmin),
    .k_step            (rom_kstep)
  );

  // steps are powers of two, so the step test is a mask
  assign k_value = {1'b0, cfg_frames} + 9'h001;
  assign k_valid = rom_valid && (k_value >= {3'h0, rom_kmin})
                   && (((k_value - {3'h0, rom_kmin}) & ({4'h0, rom_kstep} - 9'h001)) == 9'h000);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      interleave_flag         <= 1'b0;
      sample_rate_mult        <= RATE_MULT_DUAL;
      ch_a_source             <= 1'b0;
      ch_b_source             <= 1'b1;
      ch_b_phase_invert       <= 1'b0;
      datapath_single_channel <= 1'b0;
      lane_rate_mult_x8       <= 6'h00;
      serdes_pll_bypass       <= 1'b0;
    end
    else
    begin
      interleave_flag         <= rom_valid && rom_intlv;
      sample_rate_mult        <= (rom_valid && rom_intlv) ? RATE_MULT_INTLV : RATE_MULT_DUAL;
      // single input in interleave mode: both cores track the same pin; otherwise each keeps its own
      ch_a_source             <= rom_valid && rom_intlv && (active_sel == SEL_IN_B);
      ch_b_source             <= !(rom_valid && rom_intlv && (active_sel == SEL_IN_A));
      ch_b_phase_invert       <= rom_valid && rom_intlv && (active_sel == SEL_IN_BOTH);
      datapath_single_channel <= rom_valid && rom_intlv;
      lane_rate_mult_x8       <= rom_valid ? rom_r_x8 : 6'h00;
      serdes_pll_bypass       <= rom_valid && (rom_r_x8 == PLL_BYPASS_R_X8);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      encoding_64b66b       <= RST_ENC;
      ilas_enable           <= 1'b0;
      frames_per_multiframe <= 9'h000;
      ext_multiblocks       <= EXT_MULTIBLOCKS;
      ilas_did              <= RST_DID;
      ilas_scr              <= RST_SCR;
      ilas_lanes_m1         <= 4'h0;
      ilas_octets_m1        <= 4'h0;
      ilas_frames_m1        <= RST_FRAMES;
      ilas_conv_m1          <= 4'h0;
      ilas_res_m1           <= 5'h00;
      ilas_bits_m1          <= 5'h00;
      ilas_samples_m1       <= 4'h0;
    end
    else
    begin
      encoding_64b66b       <= cfg_enc;
      ilas_enable           <= link_block_enable && !cfg_enc;
      frames_per_multiframe <= cfg_enc ? 9'h000 : k_value;
      ext_multiblocks       <= EXT_MULTIBLOCKS;
      ilas_did              <= cfg_did;
      ilas_scr              <= cfg_scr;
      ilas_lanes_m1         <= rom_l - 4'h1;
      ilas_octets_m1        <= rom_f - 4'h1;
      ilas_frames_m1        <= cfg_frames;
      ilas_conv_m1          <= rom_m - 4'h1;
      ilas_res_m1           <= rom_n - 5'h01;
      ilas_bits_m1          <= rom_np - 5'h01;
      ilas_samples_m1       <= rom_s - 4'h1;
    end
  end

  // fixed fields of the alignment sequence
  assign ilas_cs        = 2'h0;
  assign ilas_hd        = 1'b0;
  assign ilas_jesdv     = ILAS_JESDV;
  assign ilas_subclassv = ILAS_SUBCLASSV;

  // two links of rom_l lanes each; lane numbers restart in the second link
  always_comb
  begin
    int lid;
    lid = 0;
    next_lane_id     = '0;
    next_lane_active = '0;
    for (int i = 0; i < NUM_LANES; i++)
    begin
      if (i < int'(rom_l))
        lid = i;
      else
        lid = i - int'(rom_l);
      next_lane_id[i*5 +: 5] = 5'(lid);
      next_lane_active[i]    = rom_valid && (i < 2 * int'(rom_l));
    end
  end

  // the sums track the snapshot every cycle, so they settle after any change
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ilas_lane_id  <= '0;
      lane_active   <= '0;
      ilas_checksum <= '0;
    end
    else
    begin
      ilas_lane_id <= next_lane_id;
      lane_active  <= next_lane_active;
      for (int i = 0; i < NUM_LANES; i++)
        ilas_checksum[i*8 +: 8] <= ilas_sum(next_lane_id[i*5 +: 5]);
    end
  end

  always_comb
  begin
    status_word                                       = '0;
    status_word[STAT_INTERLEAVE_BIT]                  = interleave_flag;
    status_word[STAT_FMT_VALID_BIT]                   = rom_valid;
    status_word[STAT_K_VALID_BIT]                     = k_valid;
    status_word[STAT_CAL_PEND_BIT]                    = cal_pending;
    status_word[STAT_ACTIVE_SEL_LSB +: 2]             = active_sel;
    status_word[STAT_RATE_LSB +: 6]                   = lane_rate_mult_x8;
    status_word[STAT_LANES_LSB +: 4]                  = rom_l;
  end

  // read data stand for one cycle only; unmapped offsets read zero
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else if (hit(reg_addr, OFS_FORMAT))
      reg_rdata <= 32'(format_sel);
    else if (hit(reg_addr, OFS_FRAMES))
      reg_rdata <= 32'(frames_field);
    else if (hit(reg_addr, OFS_DEVICE_ID))
      reg_rdata <= 32'(device_id);
    else if (hit(reg_addr, OFS_LINK_CTRL))
      reg_rdata <= 32'({enc_64, scr_en});
    else if (hit(reg_addr, OFS_LINK_EN))
      reg_rdata <= 32'(link_block_enable);
    else if (hit(reg_addr, OFS_INPUT_SEL))
      reg_rdata <= 32'(input_sel_req);
    else if (hit(reg_addr, OFS_STATUS))
      reg_rdata <= status_word;
    else if (hit(reg_addr, OFS_CHECKSUM))
      reg_rdata <= ilas_checksum[31:0];
    else
      reg_rdata <= '0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic       settled;
  logic [2:0] en_hist;
  always_ff @(posedge clk_sys)
    en_hist <= rst_n ? {en_hist[1:0], link_block_enable} : 3'h0;
  assign settled = link_block_enable && (en_hist == 3'h7);
  chk_rate_flag: assert property (interleave_flag == (sample_rate_mult == RATE_MULT_INTLV))
    else $error("sample rate multiplier disagrees with interleave flag");
  chk_phase_mode: assert property (ch_b_phase_invert |-> interleave_flag && datapath_single_channel)
    else $error("out-of-phase sampling outside single-channel mode");
  chk_cal_route: assert property (cal_done |=> active_sel == $past(input_sel_req))
    else $error("calibration did not apply the requested routing");
  chk_route_hold: assert property (!cal_done |=> $stable(active_sel))
    else $error("routing changed without calibration");
  chk_pll_bypass: assert property (serdes_pll_bypass |-> lane_rate_mult_x8 == PLL_BYPASS_R_X8)
    else $error("pll bypass with wrong lane multiplier");
  chk_k_ignored: assert property (encoding_64b66b |-> frames_per_multiframe == 9'h000)
    else $error("frames per multiframe used in 64b/66b");
  chk_e_fixed: assert property (encoding_64b66b |-> ext_multiblocks == EXT_MULTIBLOCKS)
    else $error("extended multiblock count not one");
  chk_ilas_gate: assert property (ilas_enable |-> !encoding_64b66b && $past(link_block_enable))
    else $error("alignment sequence enabled in 64b/66b or while off");
  chk_fixed_fields: assert property (ilas_cs == 2'h0 && !ilas_hd && ilas_jesdv == 3'h1
                                     && ilas_subclassv == 3'h1)
    else $error("fixed alignment field wrong");
  chk_sum_frozen: assert property (settled |-> $stable(ilas_checksum) && $stable(ilas_did))
    else $error("alignment parameters moved while link enabled");
  chk_lane_step: assert property (settled && ilas_lanes_m1 != 4'h0 && lane_active[1]
                                  |-> ilas_checksum[15:8] == ilas_checksum[7:0] + 8'h01)
    else $error("adjacent lane checksums do not differ by one");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  cov_dual_input: cover property (ch_b_phase_invert ##1 link_block_enable);
  cov_link_64b: cover property (encoding_64b66b && settled);
  cov_cal_switch: cover property (cal_pending ##1 cal_done ##1 !cal_pending);
  cov_status_read: cover property (reg_rd && hit(reg_addr, OFS_STATUS) ##1 reg_rdata[0]);

endmodule
`default_nettype wire

// ==== common/link_cfg_pkg.sv ====
package link_cfg_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int FORMAT_W = 5;
  localparam int FRAMES_W = 8;
  localparam int DID_W    = 8;

  localparam logic [ADDR_W-1:0] OFS_FORMAT    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FRAMES    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DEVICE_ID = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LINK_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LINK_EN   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INPUT_SEL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CHECKSUM  = 8'h1c;

  localparam logic [FORMAT_W-1:0] RST_FORMAT = 5'h00;
  localparam logic [FRAMES_W-1:0] RST_FRAMES = 8'h1f;
  localparam logic [DID_W-1:0]    RST_DID    = 8'h00;
  localparam logic                RST_SCR    = 1'b0;
  localparam logic                RST_ENC    = 1'b0;
  localparam logic                RST_EN     = 1'b0;

  localparam int CTRL_SCR_BIT = 0;
  localparam int CTRL_ENC_BIT = 1;
  localparam int LINK_EN_BIT  = 0;

  localparam int STAT_INTERLEAVE_BIT = 0;
  localparam int STAT_FMT_VALID_BIT  = 1;
  localparam int STAT_K_VALID_BIT    = 2;
  localparam int STAT_CAL_PEND_BIT   = 3;
  localparam int STAT_ACTIVE_SEL_LSB = 4;
  localparam int STAT_RATE_LSB       = 8;
  localparam int STAT_LANES_LSB      = 16;

  typedef enum logic [1:0] {
    SEL_IN_A    = 2'b00,
    SEL_IN_B    = 2'b01,
    SEL_IN_BOTH = 2'b11
  } input_sel_type;

  localparam logic [2:0] ILAS_JESDV      = 3'h1;
  localparam logic [2:0] ILAS_SUBCLASSV  = 3'h1;
  localparam logic [7:0] EXT_MULTIBLOCKS = 8'h01;
  localparam logic [1:0] RATE_MULT_DUAL  = 2'h1;
  localparam logic [1:0] RATE_MULT_INTLV = 2'h2;
  localparam logic [5:0] PLL_BYPASS_R_X8 = 6'h28;

endpackage

// ==== design/link_mode_rom.sv ====
`timescale 1ns/1ps
`default_nettype none
module link_mode_rom
  import link_cfg_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic [FORMAT_W-1:0] format_sel,
  output logic                     mode_valid,
  output logic                     mode_interleave,
  output logic [4:0]               sample_bits,
  output logic [1:0]               ctrl_bits,
  output logic [4:0]               packed_bits,
  output logic [3:0]               lanes_per_link,
  output logic [3:0]               converters,
  output logic [3:0]               octets_per_frame,
  output logic [3:0]               samples_per_frame,
  output logic                     mode_high_density,
  output logic [5:0]               rate_x8,
  output logic [5:0]               k_min,
  output logic [4:0]               k_step
);

  localparam int ROW_W = 48;

  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] next_row;

  // rate is stored times eight so the fractional multipliers stay exact
  function automatic logic [ROW_W-1:0] mk(input int d, input int n, input int cs, input int np,
                                           input int l, input int m, input int f, input int s,
                                           input int hd, input int r, input int kmin,
                                           input int kstep);
    mk = {1'b1, 1'(d), 5'(n), 2'(cs), 5'(np), 4'(l), 4'(m), 4'(f), 4'(s), 1'(hd),
          6'(r), 6'(kmin), 5'(kstep)};
  endfunction

  always_comb
  begin
    case (format_sel)
      5'h00:   next_row = mk(1, 12, 0, 12, 4, 4, 8, 5, 0, 32, 4, 2);
      5'h01:   next_row = mk(1, 12, 0, 12, 8, 8, 8, 5, 0, 16, 4, 2);
      5'h02:   next_row = mk(0, 12, 0, 12, 4, 4, 8, 5, 0, 32, 4, 2);
      5'h03:   next_row = mk(0, 12, 0, 12, 8, 8, 8, 5, 0, 16, 4, 2);
      5'h05:   next_row = mk(1, 8, 0, 8, 4, 1, 1, 4, 0, 20, 32, 16);
      5'h06:   next_row = mk(1, 8, 0, 8, 8, 1, 1, 8, 0, 10, 32, 16);
      5'h07:   next_row = mk(0, 8, 0, 8, 4, 1, 1, 4, 0, 20, 32, 16);
      5'h08:   next_row = mk(0, 8, 0, 8, 8, 1, 1, 8, 0, 10, 32, 16);
      5'h0a:   next_row = mk(0, 15, 1, 16, 2, 2, 2, 1, 0, 40, 16, 8);
      5'h0b:   next_row = mk(0, 15, 1, 16, 4, 2, 2, 2, 0, 20, 16, 8);
      5'h0c:   next_row = mk(0, 15, 1, 16, 8, 2, 2, 4, 0, 10, 16, 8);
      5'h0d:   next_row = mk(0, 15, 1, 16, 1, 2, 4, 1, 0, 40, 8, 4);
      5'h0e:   next_row = mk(0, 15, 1, 16, 2, 2, 2, 1, 0, 20, 16, 8);
      5'h0f:   next_row = mk(0, 15, 1, 16, 4, 2, 2, 2, 0, 10, 16, 8);
      5'h10:   next_row = mk(0, 15, 1, 16, 8, 2, 2, 4, 0, 5, 16, 8);
      5'h13:   next_row = mk(1, 12, 0, 12, 6, 1, 2, 8, 1, 20, 16, 8);
      5'h14:   next_row = mk(0, 12, 0, 12, 6, 1, 2, 8, 1, 20, 16, 8);
      5'h15:   next_row = mk(1, 15, 1, 16, 2, 1, 2, 2, 0, 40, 16, 8);
      5'h16:   next_row = mk(1, 15, 1, 16, 4, 1, 2, 4, 0, 20, 16, 8);
      5'h17:   next_row = mk(1, 15, 1, 16, 1, 1, 2, 1, 0, 40, 16, 8);
      5'h18:   next_row = mk(1, 15, 1, 16, 2, 1, 2, 2, 0, 20, 16, 8);
      5'h19:   next_row = mk(1, 15, 1, 16, 8, 1, 2, 8, 0, 10, 16, 8);
      5'h1a:   next_row = mk(1, 15, 1, 16, 4, 1, 2, 4, 0, 10, 16, 8);
      5'h1b:   next_row = mk(1, 15, 1, 16, 8, 1, 2, 8, 0, 5, 16, 8);
      default: next_row = '0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      row <= '0;
    else
      row <= next_row;
  end

  assign {mode_valid, mode_interleave, sample_bits, ctrl_bits, packed_bits, lanes_per_link,
          converters, octets_per_frame, samples_per_frame, mode_high_density, rate_x8,
          k_min, k_step} = row;

endmodule
`default_nettype wire

// ==== verif/ilas_receiver.sv ====
`timescale 1ns/1ps
`default_nettype none
module ilas_receiver
(
  input  wire logic        clk_sys,
  input  wire logic        ilas_enable,
  input  wire logic [7:0]  did,
  input  wire logic        scr,
  input  wire logic [4:0]  lane_id,
  input  wire logic [33:0] fields,
  input  wire logic [8:0]  consts,
  input  wire logic [7:0]  checksum,
  output logic             ilas_ok
);
  logic [11:0] sum;
  // a real receiver re-adds what it was sent and rejects the lane on mismatch
  assign sum = did + lane_id + scr + fields[33:30] + fields[29:26] + fields[25:18]
             + fields[17:14] + fields[13:9] + fields[8:4] + fields[3:0]
             + consts[8:7] + consts[6] + consts[5:3] + consts[2:0];
  always_ff @(posedge clk_sys)
    ilas_ok <= ilas_enable && (sum[7:0] === checksum);
endmodule
`default_nettype wire

// ==== verif/tb_link_mode_cfg.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_link_mode_cfg;
  import link_cfg_pkg::*;
  logic              clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic              cal_done = 1'b0, rd_pend = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic              interleave_flag, ch_a_source, ch_b_source, ch_b_phase_invert;
  logic              datapath_single_channel, serdes_pll_bypass, ilas_enable, ilas_scr;
  logic              ilas_hd, ilas_ok, link_block_enable, encoding_64b66b;
  logic [5:0]        lane_rate_mult_x8;
  logic [15:0]       lane_active;
  logic [1:0]        sample_rate_mult, ilas_cs;
  logic [2:0]        ilas_jesdv, ilas_subclassv;
  logic [3:0]        ilas_lanes_m1, ilas_octets_m1, ilas_conv_m1, ilas_samples_m1;
  logic [4:0]        ilas_res_m1, ilas_bits_m1;
  logic [7:0]        ext_multiblocks, ilas_did, ilas_frames_m1, did, km1;
  logic [8:0]        frames_per_multiframe;
  logic [79:0]       ilas_lane_id;
  logic [127:0]      ilas_checksum;
  logic [31:0]       exp_q[$];
  logic [31:0]       seed = 32'hf0b3;
  logic [31:0]       cw, st[6], kst;
  logic [9:0]        nb[6];
  int                fm[6];
  int                fail_count = 0;
  int                cmp_count = 0;

  link_mode_cfg u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cal_done, .link_block_enable, .interleave_flag, .sample_rate_mult, .ch_a_source,
    .ch_b_source, .ch_b_phase_invert, .datapath_single_channel, .lane_rate_mult_x8,
    .serdes_pll_bypass, .encoding_64b66b, .ilas_enable, .frames_per_multiframe,
    .ext_multiblocks, .ilas_did, .ilas_scr, .ilas_lanes_m1, .ilas_octets_m1, .ilas_frames_m1,
    .ilas_conv_m1, .ilas_res_m1, .ilas_bits_m1, .ilas_samples_m1, .ilas_cs, .ilas_hd,
    .ilas_jesdv, .ilas_subclassv, .lane_active, .ilas_lane_id, .ilas_checksum);
  ilas_receiver u_rx (.clk_sys, .ilas_enable, .did(ilas_did), .scr(ilas_scr),
    .lane_id(ilas_lane_id[4:0]), .fields({ilas_lanes_m1, ilas_octets_m1, ilas_frames_m1,
    ilas_conv_m1, ilas_res_m1, ilas_bits_m1, ilas_samples_m1}),
    .consts({ilas_cs, ilas_hd, ilas_jesdv, ilas_subclassv}), .checksum(ilas_checksum[7:0]),
    .ilas_ok);

  always #2.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // the expectation is queued here and compared by the watcher two cycles later
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    if (rd_pend)
      chk(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end

  initial
  begin
    fm = '{0, 1, 2, 3, 10, 4};
    st = '{32'h42007, 32'h81007, 32'h42006, 32'h81006, 32'h22806, 32'h0};
    // an invalid format derives zero, so its minus-one fields wrap to all ones
    nb = '{10'h16b, 10'h16b, 10'h16b, 10'h16b, 10'h1cf, 10'h3ff};
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_FRAMES, 32'h1f);
    rd(8'h20, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_FORMAT, 32'(fm[i]));
      repeat (4) @(posedge clk_sys);
      rd(OFS_STATUS, st[i]);
      chk(32'(interleave_flag), 32'(st[i][0]));
      chk(32'(serdes_pll_bypass), 32'(i == 4));
      chk(32'({ilas_res_m1, ilas_bits_m1}), 32'(nb[i]));
      chk(32'(sample_rate_mult), st[i][0] ? 32'd2 : 32'd1);
      chk(32'(lane_rate_mult_x8), 32'(st[i][13:8]));
    end
    wr(OFS_FORMAT, 32'h0);
    seed = lfsr(seed);
    did = seed[7:0];
    seed = lfsr(seed);
    km1 = seed[7:0];
    wr(OFS_DEVICE_ID, 32'(did));
    wr(OFS_FRAMES, 32'(km1));
    wr(OFS_LINK_CTRL, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk(32'(frames_per_multiframe), 32'(km1) + 1);
    chk(32'({ilas_did, ilas_scr}), {23'h0, did, 1'b1});
    chk(32'({ilas_cs, ilas_hd, ilas_jesdv, ilas_subclassv}), 32'h9);
    chk(32'({ilas_lanes_m1, ilas_octets_m1, ilas_conv_m1, ilas_samples_m1}), 32'h3734);
    chk(32'(ilas_frames_m1), 32'(km1));
    chk(32'(lane_active), 32'h00ff);
    for (int i = 0; i < 8; i++)
    begin
      chk(32'(ilas_lane_id[i*5+:5]), i % 4);
      chk(32'(ilas_checksum[i*8+:8]), (did + km1 + i % 4 + 42) & 32'hff);
      if (i < 4)
        cw[i*8+:8] = 8'(did + km1 + i + 42);
    end
    rd(OFS_CHECKSUM, cw);
    wr(OFS_LINK_EN, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(32'({ilas_enable, ilas_ok}), 32'h3);
    wr(OFS_DEVICE_ID, 32'(did ^ 8'h5a));
    repeat (4) @(posedge clk_sys);
    chk(32'(ilas_checksum[7:0]), 32'(cw[7:0]));
    wr(OFS_LINK_EN, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk(32'(ilas_checksum[7:0]), ((did ^ 8'h5a) + km1 + 42) & 32'hff);
    wr(OFS_LINK_CTRL, 32'h2);
    repeat (3) @(posedge clk_sys);
    wr(OFS_LINK_EN, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk(32'({ilas_enable, frames_per_multiframe, ext_multiblocks}), 32'h1);
    chk(32'({encoding_64b66b, link_block_enable}), 32'h3);
    wr(OFS_LINK_EN, 32'h0);
    // host routes both inputs, then calibrates before routing may change
    wr(OFS_INPUT_SEL, 32'h3);
    repeat (4) @(posedge clk_sys);
    kst = 32'h42003 | ((km1 >= 8'd3 && km1[0]) ? 32'h4 : 32'h0);
    rd(OFS_STATUS, kst | 32'h8);
    chk(32'(ch_b_phase_invert), 32'h0);
    @(posedge clk_sys);
    cal_done <= 1'b1;
    @(posedge clk_sys);
    cal_done <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(32'({ch_a_source, ch_b_source, ch_b_phase_invert, datapath_single_channel}), 32'h7);
    rd(OFS_STATUS, kst | 32'h30);
    for (int i = 0; i < 8 && exp_q.size() > 0; i++)
      @(posedge clk_sys);
    if (exp_q.size() > 0)
      fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
